// File: ohi_pkg.sv
// Shared constants and types for the OLED host port, both ends.
// Assumes one clock domain per end; the pins pass between ends.
package ohi_pkg;

  // Strap code is {protocol_strap_b, protocol_strap_a}
  typedef enum logic [1:0] {
    M_SER = 2'b00,
    M_I2C = 2'b01,
    M_68  = 2'b10,
    M_80  = 2'b11
  } ohi_mode_t;

  // Bit positions of the sampled pin vector in the device end
  localparam int P_CS   = 0;
  localparam int P_RST  = 1;
  localparam int P_DC   = 2;
  localparam int P_RW   = 3;
  localparam int P_EN   = 4;
  localparam int P_D0   = 5;
  localparam int P_SA   = 13;
  localparam int P_SB   = 14;
  localparam int NPIN   = 15;

  // Host step sequencer: index of the last step per mode, and two-wire bit steps
  localparam logic [5:0] LAST_PAR = 6'h02;
  localparam logic [5:0] LAST_SER = 6'h11;
  localparam logic [5:0] LAST_I2C = 6'h3A;
  localparam logic [5:0] I2C_BIT0 = 6'h02;
  localparam logic [5:0] I2C_BITN = 6'h37;
  localparam logic [5:0] BITS_BYTE_ACK = 6'h09;
  localparam logic [5:0] ACK_POS  = 6'h08;

  // Device bit counter in two-wire and serial modes
  localparam logic [3:0] CNT_ACK  = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  localparam logic [3:0] SER_LAST = 4'h7;

  // Output enables, active low
  localparam logic [7:0] OE_NONE  = 8'hFF;
  localparam logic [7:0] OE_ALL   = 8'h00;
  localparam logic [7:0] OE_ACK   = 8'hFB;
  localparam logic [7:0] OE_SER   = 8'hFC;

endpackage

// File: ohi_if.sv
// Pin bundle between the host controller and the display device.
// Models pull-ups on the data lines; low wins; D2 and D1 tied in two-wire.
`timescale 1ns/1ns
interface ohi_if;
  import ohi_pkg::*;

  logic       protocol_strap_a;
  logic       protocol_strap_b;
  logic       chip_sel_n;
  logic       reset_low;
  logic       data_cmd_sel;
  logic       dir_wr_n;
  logic       en_rd;
  logic [7:0] host_d_o;
  logic [7:0] host_d_oe_n;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe_n;
  logic [7:0] host_data_bus;
  logic [7:0] lvl;
  logic       tie;

  assign lvl = ~((~host_d_oe_n & ~host_d_o) | (~dev_d_oe_n & ~dev_d_o));
  assign tie = ({protocol_strap_b, protocol_strap_a} == M_I2C);
  assign host_data_bus = tie ?
    {lvl[7:3], lvl[2] & lvl[1], lvl[2] & lvl[1], lvl[0]} : lvl;

  modport dev_mp (
    input  protocol_strap_a, protocol_strap_b, chip_sel_n, reset_low,
    input  data_cmd_sel, dir_wr_n, en_rd, host_data_bus,
    output dev_d_o, dev_d_oe_n
  );

  modport host_mp (
    output protocol_strap_a, protocol_strap_b, chip_sel_n, reset_low,
    output data_cmd_sel, dir_wr_n, en_rd, host_d_o, host_d_oe_n,
    input  host_data_bus
  );

endinterface

// File: ohi_dev.sv
// Device end of the OLED host port: decodes the four host protocols.
// Assumes all pins arrive asynchronously and rd_data_i is on clk_i.
`timescale 1ns/1ns
module ohi_dev #(
  parameter logic [5:0] I2C_ADDR_HI = 6'h2A
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  ohi_if.dev_mp                  pin,
  input  wire logic [7:0]        rd_data_i,
  output logic                   cmd_valid_o,
  output logic [7:0]             cmd_byte_o,
  output logic                   cmd_is_data_o,
  output logic                   rd_req_o,
  output ohi_pkg::ohi_mode_t     mode_o,
  output logic                   ctrl_reset_o
);
  import ohi_pkg::*;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_CTRL = 2'b11,
    I_DATA = 2'b10
  } ohi_i2c_t;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] flt;
    logic [NPIN-1:0] prv;
    ohi_i2c_t        i2c;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic            ack;
    logic            co;
    logic            dcsel;
    logic            drv;
    logic [7:0]      dout;
    logic            cmd_valid;
    logic [7:0]      cmd_byte;
    logic            cmd_is_data;
    logic            rd_req;
    logic            init;
  } ohi_dev_st_t;

  ohi_dev_st_t     r_reg;
  ohi_dev_st_t     r_next;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] unst;
  logic [7:0]      dbus;
  logic [7:0]      sbyte;
  logic            sel;
  logic            sda;
  logic            start;
  logic            stop;
  ohi_mode_t       mode;

  assign pins = {pin.protocol_strap_b, pin.protocol_strap_a,
                 pin.host_data_bus, pin.en_rd, pin.dir_wr_n,
                 pin.data_cmd_sel, pin.reset_low, pin.chip_sel_n};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    // Three-stage sampler; a change counts once stages two and three agree
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    unst = r_reg.s2 ^ r_reg.s3;
    r_next.flt = (r_reg.s3 & ~unst) | (r_reg.flt & unst);
    r_next.prv = r_reg.flt;
    r_next.cmd_valid = 1'b0;
    r_next.rd_req = 1'b0;
    r_next.init = ~r_reg.flt[P_RST];
    mode = ohi_mode_t'({r_reg.flt[P_SB], r_reg.flt[P_SA]});
    sel = ~r_reg.flt[P_CS];
    dbus = r_reg.flt[P_D0 +: 8];
    rise = r_reg.flt & ~r_reg.prv;
    fall = ~r_reg.flt & r_reg.prv;
    sbyte = {r_reg.sh[6:0], dbus[1]};
    sda = dbus[1];
    start = dbus[0] & r_reg.prv[P_D0] & r_reg.prv[P_D0+1] & ~sda;
    stop = dbus[0] & r_reg.prv[P_D0] & ~r_reg.prv[P_D0+1] & sda;
    if (!r_reg.flt[P_RST] || !sel) begin
      // Reset pin low or chip deselected: drop every transfer in flight
      r_next.drv = 1'b0;
      r_next.cnt = '0;
      r_next.i2c = I_IDLE;
      r_next.ack = 1'b0;
      if (!r_reg.flt[P_RST]) begin
        r_next.co = 1'b0;
        r_next.dcsel = 1'b0;
        r_next.sh = '0;
      end
    end else begin
      case (mode)
        M_68: begin
          // Enable high with chip select low opens a cycle
          if (rise[P_EN] && r_reg.flt[P_RW]) begin
            r_next.rd_req = 1'b1;
            r_next.dout = rd_data_i;
          end
          r_next.drv = r_reg.flt[P_EN] & r_reg.flt[P_RW];
          if (fall[P_EN] && !r_reg.flt[P_RW]) begin
            r_next.cmd_valid = 1'b1;
            r_next.cmd_byte = dbus;
            r_next.cmd_is_data = r_reg.flt[P_DC];
          end
        end
        M_80: begin
          // Write byte is taken as the write strobe returns high
          if (rise[P_RW]) begin
            r_next.cmd_valid = 1'b1;
            r_next.cmd_byte = dbus;
            r_next.cmd_is_data = r_reg.flt[P_DC];
          end
          if (fall[P_EN]) begin
            r_next.rd_req = 1'b1;
            r_next.dout = rd_data_i;
          end
          r_next.drv = ~r_reg.flt[P_EN];
        end
        M_SER: begin
          r_next.drv = 1'b0;
          if (rise[P_D0]) begin
            r_next.sh = sbyte;
            if (r_reg.cnt == SER_LAST) begin
              r_next.cnt = '0;
              r_next.cmd_valid = 1'b1;
              r_next.cmd_byte = sbyte;
              r_next.cmd_is_data = r_reg.flt[P_DC];
            end else begin
              r_next.cnt = r_reg.cnt + 4'h1;
            end
          end
        end
        M_I2C: begin
          r_next.drv = 1'b0;
          if (start) begin
            r_next.i2c = I_ADDR;
            r_next.cnt = '0;
            r_next.ack = 1'b0;
          end else if (stop) begin
            r_next.i2c = I_IDLE;
            r_next.ack = 1'b0;
          end else if (r_reg.i2c != I_IDLE) begin
            if (rise[P_D0] && r_reg.cnt < CNT_ACK) begin
              r_next.sh = sbyte;
              r_next.cnt = r_reg.cnt + 4'h1;
            end else if (fall[P_D0] && r_reg.cnt == CNT_ACK) begin
              // Byte complete: pull the acknowledge line for one clock
              r_next.cnt = CNT_DONE;
              r_next.ack = 1'b1;
              case (r_reg.i2c)
                I_ADDR: begin
                  if (r_reg.sh == {I2C_ADDR_HI, r_reg.flt[P_DC], 1'b0}) begin
                    r_next.i2c = I_CTRL;
                  end else begin
                    r_next.i2c = I_IDLE;
                    r_next.ack = 1'b0;
                  end
                end
                I_CTRL: begin
                  r_next.co = r_reg.sh[7];
                  r_next.dcsel = r_reg.sh[6];
                  r_next.i2c = I_DATA;
                end
                I_DATA: begin
                  r_next.cmd_valid = 1'b1;
                  r_next.cmd_byte = r_reg.sh;
                  r_next.cmd_is_data = r_reg.dcsel;
                  r_next.i2c = r_reg.co ? I_CTRL : I_DATA;
                end
                default: begin
                  r_next.i2c = I_IDLE;
                end
              endcase
            end else if (fall[P_D0] && r_reg.cnt == CNT_DONE) begin
              r_next.cnt = '0;
              r_next.ack = 1'b0;
            end
          end
        end
        default: begin
          r_next.drv = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.init <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pin.dev_d_o = r_reg.drv ? r_reg.dout : 8'h00;
  assign pin.dev_d_oe_n = r_reg.drv ? OE_ALL : (r_reg.ack ? OE_ACK : OE_NONE);
  assign cmd_valid_o = r_reg.cmd_valid;
  assign cmd_byte_o = r_reg.cmd_byte;
  assign cmd_is_data_o = r_reg.cmd_is_data;
  assign rd_req_o = r_reg.rd_req;
  assign mode_o = ohi_mode_t'({r_reg.flt[P_SB], r_reg.flt[P_SA]});
  assign ctrl_reset_o = r_reg.init;

endmodule

// File: ohi_host.sv
// Host end of the OLED host port: one byte per request in any mode.
// Assumes the device end samples pins with a few cycles of latency.
`timescale 1ns/1ns
module ohi_host #(
  parameter int         STEP_CYC    = 12,
  parameter logic       I2C_SA0     = 1'b0,
  parameter logic [5:0] I2C_ADDR_HI = 6'h2A
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  ohi_if.host_mp                 pin,
  input  ohi_pkg::ohi_mode_t     mode_i,
  input  wire logic              dev_reset_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_read_i,
  input  wire logic              req_is_data_i,
  input  wire logic [7:0]        req_byte_i,
  output logic                   rd_valid_o,
  output logic [7:0]             rd_byte_o
);
  import ohi_pkg::*;

  typedef enum logic {
    H_IDLE = 1'b0,
    H_RUN  = 1'b1
  } ohi_hst_t;

  typedef struct packed {
    ohi_hst_t   st;
    ohi_mode_t  mode;
    logic [5:0] step;
    logic [7:0] tick;
    logic [7:0] dat;
    logic       is_data;
    logic       is_read;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] flt;
    logic       rd_valid;
    logic [7:0] rd_byte;
    logic       cs_n;
    logic       rstl;
    logic       dc;
    logic       rw;
    logic       en;
    logic [7:0] dq;
    logic [7:0] doe_n;
  } ohi_host_st_t;

  ohi_host_st_t r_reg;
  ohi_host_st_t r_next;
  logic         run;
  logic [5:0]   s;
  logic [5:0]   j;
  logic [5:0]   bn;
  logic [5:0]   by;
  logic [5:0]   pos;
  logic [23:0]  fsh;
  logic [7:0]   unst;
  logic         scl;
  logic         sda;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin.host_data_bus;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    unst = r_reg.s2 ^ r_reg.s3;
    r_next.flt = (r_reg.s3 & ~unst) | (r_reg.flt & unst);
    r_next.rd_valid = 1'b0;
    r_next.rstl = ~dev_reset_i;
    case (r_reg.st)
      H_IDLE: begin
        r_next.mode = mode_i;
        if (req_valid_i) begin
          r_next.st = H_RUN;
          r_next.step = '0;
          r_next.tick = 8'(STEP_CYC - 1);
          r_next.dat = req_byte_i;
          r_next.is_data = req_is_data_i;
          r_next.is_read = req_read_i & mode_i[1];
        end
      end
      H_RUN: begin
        if (r_reg.tick != 8'h00) begin
          r_next.tick = r_reg.tick - 8'h01;
        end else begin
          r_next.tick = 8'(STEP_CYC - 1);
          if (r_reg.is_read && r_reg.step == 6'h01) begin
            r_next.rd_valid = 1'b1;
            r_next.rd_byte = r_reg.flt;
          end
          if ((r_reg.mode[1] && r_reg.step == LAST_PAR) ||
              (r_reg.mode == M_SER && r_reg.step == LAST_SER) ||
              (r_reg.mode == M_I2C && r_reg.step == LAST_I2C)) begin
            r_next.st = H_IDLE;
          end else begin
            r_next.step = r_reg.step + 6'h01;
          end
        end
      end
      default: begin
        r_next.st = H_IDLE;
      end
    endcase

    // Pin levels follow the next step, so they leave flip-flops
    run = (r_next.st == H_RUN);
    s = r_next.step;
    j = s - 6'h01;
    bn = 6'((s - I2C_BIT0) >> 1);
    by = bn / BITS_BYTE_ACK;
    pos = bn % BITS_BYTE_ACK;
    fsh = {I2C_ADDR_HI, I2C_SA0, 1'b0, 1'b0, r_next.is_data, 6'h00,
           r_next.dat} << (6'(by << 3) + pos);
    scl = 1'b1;
    sda = 1'b1;
    r_next.cs_n = ~run;
    r_next.dc = r_next.is_data;
    r_next.rw = 1'b1;
    r_next.en = 1'b0;
    r_next.dq = r_next.dat;
    r_next.doe_n = (run && !r_next.is_read) ? OE_ALL : OE_NONE;
    case (r_next.mode)
      M_68: begin
        r_next.rw = ~run | r_next.is_read;
        r_next.en = run && s == 6'h01;
      end
      M_80: begin
        r_next.rw = ~(run && s == 6'h01 && !r_next.is_read);
        r_next.en = ~(run && s == 6'h01 && r_next.is_read);
      end
      M_SER: begin
        scl = run && s != 6'h00 && s != LAST_SER && j[0];
        sda = r_next.dat[3'h7 - j[3:1]];
        r_next.dq = {6'h00, sda, scl};
        r_next.doe_n = OE_SER;
      end
      M_I2C: begin
        r_next.cs_n = 1'b0;
        r_next.dc = I2C_SA0;
        if (run) begin
          if (s == 6'h01) begin
            sda = 1'b0;
          end else if (s >= I2C_BIT0 && s <= I2C_BITN) begin
            scl = s[0];
            sda = (pos == ACK_POS) ? 1'b1 : fsh[23];
          end else if (s == I2C_BITN + 6'h01) begin
            scl = 1'b0;
            sda = 1'b0;
          end else if (s == I2C_BITN + 6'h02) begin
            sda = 1'b0;
          end
        end
        r_next.dq = {7'h00, scl};
        r_next.doe_n = {6'h3F, sda, 1'b0};
      end
      default: begin
        r_next.doe_n = OE_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.cs_n <= 1'b1;
      r_reg.rw <= 1'b1;
      r_reg.doe_n <= OE_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pin.protocol_strap_a = r_reg.mode[0];
  assign pin.protocol_strap_b = r_reg.mode[1];
  assign pin.chip_sel_n = r_reg.cs_n;
  assign pin.reset_low = r_reg.rstl;
  assign pin.data_cmd_sel = r_reg.dc;
  assign pin.dir_wr_n = r_reg.rw;
  assign pin.en_rd = r_reg.en;
  assign pin.host_d_o = r_reg.dq;
  assign pin.host_d_oe_n = r_reg.doe_n;
  assign req_ready_o = (r_reg.st == H_IDLE);
  assign rd_valid_o = r_reg.rd_valid;
  assign rd_byte_o = r_reg.rd_byte;

endmodule

// File: ohi_props.sv
// Checker for the pins between the host end and the device end.
// Assumes instantiation in tb beside the interface, on the host clock.
`timescale 1ns/1ns
module ohi_props
  import ohi_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       protocol_strap_a,
  input wire logic       protocol_strap_b,
  input wire logic       chip_sel_n,
  input wire logic       reset_low,
  input wire logic       data_cmd_sel,
  input wire logic       dir_wr_n,
  input wire logic       en_rd,
  input wire logic [7:0] host_d_o,
  input wire logic [7:0] host_d_oe_n,
  input wire logic [7:0] dev_d_o,
  input wire logic [7:0] dev_d_oe_n,
  input wire logic [7:0] host_data_bus
);
  logic [1:0] strap;
  logic       par;

  assign strap = {protocol_strap_b, protocol_strap_a};
  assign par   = strap[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////
  a_cs_idle_quiet: assert property (
    chip_sel_n [*8] |-> dev_d_oe_n == OE_NONE)
    else $error("device drives bus while deselected");
  a_rst_quiet: assert property (
    (!reset_low) [*8] |-> dev_d_oe_n == OE_NONE)
    else $error("device drives bus while held in reset");
  a_dc_steady: assert property (
    par && !chip_sel_n && !$past(chip_sel_n) |-> $stable(data_cmd_sel))
    else $error("selector moved inside a parallel transfer");
  a_68_wr_quiet: assert property (
    (strap == M_68 && !dir_wr_n) [*8] |-> dev_d_oe_n == OE_NONE)
    else $error("device drives bus during 68 write");
  a_68_rd_drive: assert property (
    (strap == M_68 && !chip_sel_n && dir_wr_n && en_rd) [*8]
      |-> dev_d_oe_n == OE_ALL && host_d_oe_n == OE_NONE)
    else $error("68 read not driven by device alone");
  a_80_rd_drive: assert property (
    (strap == M_80 && !chip_sel_n && !en_rd) [*8]
      |-> dev_d_oe_n == OE_ALL)
    else $error("80 read strobe low without device drive");
  a_80_wr_drive: assert property (
    strap == M_80 && !chip_sel_n && !dir_wr_n |-> host_d_oe_n == OE_ALL)
    else $error("80 write strobe low without host drive");
  a_80_idle_quiet: assert property (
    (strap == M_80 && en_rd) [*8] |-> dev_d_oe_n == OE_NONE)
    else $error("device drives bus with read strobe high");
  a_ser_data_setup: assert property (
    strap == M_SER && !chip_sel_n && $rose(host_data_bus[0])
      |-> $stable(host_data_bus[1]) && dev_d_oe_n == OE_NONE)
    else $error("serial data moved at clock rise");
  a_i2c_ack_only: assert property (
    (strap == M_I2C) [*4] |-> dev_d_oe_n inside {OE_NONE, OE_ACK})
    else $error("two-wire device drives other than acknowledge line");
  a_i2c_host_lines: assert property (
    strap == M_I2C |-> host_d_oe_n[0] == 1'b0 && host_d_oe_n[7:2] == 6'h3F)
    else $error("two-wire host drives lines other than clock and data");
endmodule

// File: tb.sv
// Testbench: host end and device end joined by the pin interface.
// Assumes both ends share clk_i; a queue model predicts every command and read byte.
`timescale 1ns/1ns
module tb;
  import ohi_pkg::*;

  logic       clk_i         = 1'b0;
  logic       sys_rst_i     = 1'b1;
  ohi_mode_t  mode_i        = M_SER;
  logic       dev_reset_i   = 1'b0;
  logic       req_valid_i   = 1'b0;
  logic       req_read_i    = 1'b0;
  logic       req_is_data_i = 1'b0;
  logic [7:0] req_byte_i    = 8'h00;
  logic [7:0] rd_data_i     = 8'h00;
  logic       req_ready_o;
  logic       rd_valid_o;
  logic [7:0] rd_byte_o;
  logic       cmd_valid_o;
  logic [7:0] cmd_byte_o;
  logic       cmd_is_data_o;
  logic       rd_req_o;
  ohi_mode_t  mode_o;
  logic       ctrl_reset_o;
  int         num_errors    = 0;
  int         compares      = 0;
  int         cycles        = 0;
  int         seed;
  int         rd_exp        = 0;
  int         rd_seen       = 0;
  logic [8:0] exp_wr[$];
  logic [7:0] exp_rd[$];

  always #4 clk_i = ~clk_i;

  ohi_if pin_if ();
  ohi_host ohi_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pin(pin_if), .mode_i(mode_i), .dev_reset_i(dev_reset_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_read_i(req_read_i), .req_is_data_i(req_is_data_i),
    .req_byte_i(req_byte_i), .rd_valid_o(rd_valid_o),
    .rd_byte_o(rd_byte_o));
  ohi_dev ohi_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pin(pin_if), .rd_data_i(rd_data_i), .cmd_valid_o(cmd_valid_o),
    .cmd_byte_o(cmd_byte_o), .cmd_is_data_o(cmd_is_data_o),
    .rd_req_o(rd_req_o), .mode_o(mode_o), .ctrl_reset_o(ctrl_reset_o));
  ohi_props ohi_props_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .protocol_strap_a(pin_if.protocol_strap_a),
    .protocol_strap_b(pin_if.protocol_strap_b),
    .chip_sel_n(pin_if.chip_sel_n), .reset_low(pin_if.reset_low),
    .data_cmd_sel(pin_if.data_cmd_sel), .dir_wr_n(pin_if.dir_wr_n),
    .en_rd(pin_if.en_rd), .host_d_o(pin_if.host_d_o),
    .host_d_oe_n(pin_if.host_d_oe_n), .dev_d_o(pin_if.dev_d_o),
    .dev_d_oe_n(pin_if.dev_d_oe_n), .host_data_bus(pin_if.host_data_bus));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One request; the expectation is queued before the host takes it
  task automatic xfer(input logic rd, input logic dat, input int gap);
    int n;
    rd_data_i     = 8'($random(seed));
    req_byte_i    = 8'($random(seed));
    req_read_i    = rd;
    req_is_data_i = dat;
    if (rd) begin
      exp_rd.push_back(rd_data_i);
      rd_exp++;
    end else begin
      exp_wr.push_back({dat, req_byte_i});
    end
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 1000) begin
      num_errors++;
    end
    repeat (gap) @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  // Pulses are sampled mid-cycle, where they stand settled
  always @(negedge clk_i) begin
    if (!sys_rst_i && cmd_valid_o === 1'b1) begin
      check(9'(exp_wr.size() != 0), 9'h001);
      if (exp_wr.size() != 0) begin
        check({cmd_is_data_o, cmd_byte_o}, exp_wr.pop_front());
      end
    end
    if (!sys_rst_i && rd_valid_o === 1'b1) begin
      check(9'(exp_rd.size() != 0), 9'h001);
      if (exp_rd.size() != 0) begin
        check({1'b0, rd_byte_o}, {1'b0, exp_rd.pop_front()});
      end
    end
    if (!sys_rst_i && rd_req_o === 1'b1) begin
      rd_seen++;
    end
  end

  initial begin
    seed = 53519;
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int m = 0; m < 4; m++) begin
      mode_i = ohi_mode_t'(m[1:0]);
      repeat (12) @(negedge clk_i);
      check({7'h00, mode_o}, {7'h00, mode_i});
      // Command, then data with no gap before the next two, which are reads in parallel modes
      for (int k = 0; k < 4; k++) begin
        xfer(m[1] && k >= 2, k[0], k == 1 ? 0 : 10);
      end
    end
    mode_i = M_68;
    repeat (12) @(negedge clk_i);
    dev_reset_i = 1'b1;
    repeat (12) @(negedge clk_i);
    check({8'h00, ctrl_reset_o}, 9'h001);
    dev_reset_i = 1'b0;
    repeat (12) @(negedge clk_i);
    check({8'h00, ctrl_reset_o}, 9'h000);
    xfer(1'b0, 1'b1, 10);
    xfer(1'b1, 1'b0, 10);
    check(9'(exp_wr.size()), 9'h000);
    check(9'(rd_seen), 9'(rd_exp));
    check(9'(exp_rd.size()), 9'h000);
    results();
  end
endmodule
